// file: verilog/core_status_and_pointer_regs.sv
`timescale 1ns/1ps

module core_status_and_pointer_regs
(
	// Clock, reset, enable
	input  wire logic                   sys_clk,
	input  wire logic                   rst_b,
	input  wire logic                   clk_en,
	// Special-function-register port
	input  wire logic [7:0]             sfr_addr,
	input  wire logic                   sfr_wr,
	input  wire logic                   sfr_bit_wr,
	input  wire logic [2:0]             sfr_bit_sel,
	input  wire logic [7:0]             sfr_wdata,
	input  wire logic                   sfr_rd,
	output logic      [7:0]             sfr_rdata,
	output logic                        sfr_rd_ack,
	// Arithmetic execution
	input  wire logic                   alu_go,
	input  wire core_regs_pkg::alu_op_t alu_op,
	input  wire logic [7:0]             alu_operand_b,
	output logic      [7:0]             alu_result_hi,
	// Accumulator load and stack
	input  wire logic                   acc_load,
	input  wire logic [7:0]             acc_load_data,
	input  wire logic                   push_req,
	input  wire logic [7:0]             push_data,
	input  wire logic                   pop_req,
	output logic                        push_busy,
	output logic                        stack_wr_en,
	output logic      [7:0]             stack_wr_addr,
	output logic      [7:0]             stack_wr_data,
	// Architectural state
	output logic      [15:0]            sixteen_bit_pointer,
	output logic      [7:0]             stack_top_index,
	output logic      [7:0]             arith_main_operand,
	output logic      [7:0]             flags_word,
	output logic      [4:0]             bank_base_addr
);

	// ==========================================================
	// Register state
	logic [7:0] sp_q, sp_d;
	logic [7:0] dpl_q, dph_q;
	logic [7:0] acc_q, acc_d;
	logic [7:0] psw_q, psw_d;
	logic       parity_q;
	logic [7:0] push_data_q;
	logic [7:0] hi_q;
	core_regs_pkg::push_state_t state_q, state_d;

	// Byte write or single-bit write merged through one mask
	logic [7:0] wmask;
	logic [7:0] wval;
	logic       push_take;

	always_comb
	begin
		wmask = 8'h00;
		wval  = sfr_wdata;
		if (sfr_wr)
		begin
			wmask = 8'hff;
		end
		else if (sfr_bit_wr)
		begin
			wmask = 8'h01 << sfr_bit_sel;
			wval  = {8{sfr_wdata[0]}};
		end
	end

	function automatic logic [7:0] merge(input logic [7:0] old_v);
		merge = (old_v & ~wmask) | (wval & wmask);
	endfunction

	// ==========================================================
	// Arithmetic flags
	logic [7:0] alu_lo, alu_hi;
	logic       alu_cy, alu_ac, alu_ov;

	flag_alu flag_alu_i
	(
		.a      (acc_q),
		.b      (alu_operand_b),
		.cy_in  (psw_q[core_regs_pkg::CARRY_FLAG_POS]),
		.op     (alu_op),
		.res_lo (alu_lo),
		.res_hi (alu_hi),
		.cy     (alu_cy),
		.ac     (alu_ac),
		.ov     (alu_ov)
	);

	// Software write wins over an instruction result in the same cycle
	always_comb
	begin
		acc_d = acc_q;
		if (alu_go)
		begin
			acc_d = alu_lo;
		end
		if (acc_load)
		begin
			acc_d = acc_load_data;
		end
		if (sfr_addr == core_regs_pkg::ARITH_MAIN_OPERAND_OFS)
		begin
			acc_d = merge(acc_d);
		end
	end

	always_comb
	begin
		psw_d = psw_q;
		if (alu_go)
		begin
			// Only carry, half-carry and overflow follow results
			psw_d[core_regs_pkg::CARRY_FLAG_POS]      = alu_cy;
			psw_d[core_regs_pkg::HALF_CARRY_FLAG_POS] = alu_ac;
			psw_d[core_regs_pkg::SIGNED_ERR_FLAG_POS] = alu_ov;
		end
		if (sfr_addr == core_regs_pkg::FLAGS_WORD_OFS)
		begin
			psw_d = merge(psw_d);
		end
		psw_d[core_regs_pkg::PARITY_POS] = 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			acc_q    <= core_regs_pkg::ARITH_MAIN_OPERAND_RST;
			psw_q    <= core_regs_pkg::FLAGS_WORD_RST;
			parity_q <= 1'b0;
			hi_q     <= 8'h00;
		end
		else if (clk_en)
		begin
			acc_q    <= acc_d;
			psw_q    <= psw_d;
			parity_q <= ^acc_d;
			if (alu_go)
			begin
				hi_q <= alu_hi;
			end
		end
	end

	// ==========================================================
	// Data pointer bytes
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			dpl_q <= core_regs_pkg::POINTER_LOW_BYTE_RST;
			dph_q <= core_regs_pkg::POINTER_HIGH_BYTE_RST;
		end
		else if (clk_en)
		begin
			if (sfr_addr == core_regs_pkg::POINTER_LOW_BYTE_OFS)
			begin
				dpl_q <= merge(dpl_q);
			end
			if (sfr_addr == core_regs_pkg::POINTER_HIGH_BYTE_OFS)
			begin
				dph_q <= merge(dph_q);
			end
		end
	end

	// ==========================================================
	// Stack index and push sequencer
	// A push is two cycles so the write always sees the new index
	assign push_take = push_req && (state_q == core_regs_pkg::ST_IDLE);

	always_comb
	begin
		sp_d    = sp_q;
		state_d = state_q;
		case (state_q)
			core_regs_pkg::ST_IDLE:
			begin
				if (push_take)
				begin
					sp_d    = sp_q + 8'h01;
					state_d = core_regs_pkg::ST_PUSH_WR;
				end
				else if (pop_req)
				begin
					sp_d = sp_q - 8'h01;
				end
			end
			core_regs_pkg::ST_PUSH_WR:
			begin
				state_d = core_regs_pkg::ST_IDLE;
			end
			default:
			begin
				state_d = core_regs_pkg::ST_IDLE;
			end
		endcase
		if (sfr_addr == core_regs_pkg::STACK_TOP_INDEX_OFS)
		begin
			sp_d = merge(sp_d);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			sp_q        <= core_regs_pkg::STACK_TOP_INDEX_RST;
			state_q     <= core_regs_pkg::ST_IDLE;
			push_data_q <= 8'h00;
		end
		else if (clk_en)
		begin
			sp_q    <= sp_d;
			state_q <= state_d;
			if (push_take)
			begin
				push_data_q <= push_data;
			end
		end
	end

	// Write strobe comes after the index has moved
	assign stack_wr_en   = (state_q == core_regs_pkg::ST_PUSH_WR)
		&& clk_en;
	assign stack_wr_addr = sp_q;
	assign stack_wr_data = push_data_q;
	assign push_busy     = (state_q != core_regs_pkg::ST_IDLE);

	// ==========================================================
	// Read port
	logic [7:0] rd_mux;

	always_comb
	begin
		case (sfr_addr)
			core_regs_pkg::STACK_TOP_INDEX_OFS:    rd_mux = sp_q;
			core_regs_pkg::POINTER_LOW_BYTE_OFS:   rd_mux = dpl_q;
			core_regs_pkg::POINTER_HIGH_BYTE_OFS:  rd_mux = dph_q;
			core_regs_pkg::FLAGS_WORD_OFS:         rd_mux = flags_word;
			core_regs_pkg::ARITH_MAIN_OPERAND_OFS: rd_mux = acc_q;
			// Undefined locations are reserved and read as zero
			default:
			begin
				rd_mux = core_regs_pkg::UNMAPPED_READ_VAL;
			end
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			sfr_rdata  <= 8'h00;
			sfr_rd_ack <= 1'b0;
		end
		else if (clk_en)
		begin
			sfr_rd_ack <= sfr_rd;
			if (sfr_rd)
			begin
				sfr_rdata <= rd_mux;
			end
		end
	end

	// ==========================================================
	// Architectural outputs
	assign sixteen_bit_pointer = {dph_q, dpl_q};
	assign stack_top_index     = sp_q;
	assign arith_main_operand  = acc_q;
	assign alu_result_hi       = hi_q;
	assign flags_word          = {psw_q[7:1], parity_q};
	assign bank_base_addr      = {psw_q[core_regs_pkg::BANK_SELECT_HI_POS],
		psw_q[core_regs_pkg::BANK_SELECT_LO_POS],
		3'b000};

endmodule // core_status_and_pointer_regs

// file: pkg/core_regs_pkg.sv
package core_regs_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] STACK_TOP_INDEX_OFS    = 8'h81;
	localparam logic [7:0] POINTER_LOW_BYTE_OFS   = 8'h82;
	localparam logic [7:0] POINTER_HIGH_BYTE_OFS  = 8'h83;
	localparam logic [7:0] FLAGS_WORD_OFS         = 8'hd0;
	localparam logic [7:0] ARITH_MAIN_OPERAND_OFS = 8'hf0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] STACK_TOP_INDEX_RST    = 8'h07;
	localparam logic [7:0] POINTER_LOW_BYTE_RST   = 8'h00;
	localparam logic [7:0] POINTER_HIGH_BYTE_RST  = 8'h00;
	localparam logic [7:0] FLAGS_WORD_RST         = 8'h00;
	localparam logic [7:0] ARITH_MAIN_OPERAND_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VAL      = 8'h00;

	// ==========================================================
	// Flags word field positions
	localparam int CARRY_FLAG_POS        = 7;
	localparam int HALF_CARRY_FLAG_POS   = 6;
	localparam int USER_FLAG_A_POS       = 5;
	localparam int BANK_SELECT_HI_POS    = 4;
	localparam int BANK_SELECT_LO_POS    = 3;
	localparam int SIGNED_ERR_FLAG_POS   = 2;
	localparam int USER_FLAG_B_POS       = 1;
	localparam int PARITY_POS            = 0;
	localparam int BANK_SIZE_LOG2        = 3;

	// ==========================================================
	// Arithmetic operations
	typedef enum logic [2:0]
	{
		OP_ADD                  = 3'h0,
		OP_ADD_WITH_CARRY       = 3'h1,
		OP_SUBTRACT_WITH_BORROW = 3'h2,
		OP_MUL                  = 3'h3,
		OP_DIV                  = 3'h4
	} alu_op_t;

	// Push sequencer, Gray coded
	typedef enum logic [1:0]
	{
		ST_IDLE     = 2'b00,
		ST_PUSH_WR  = 2'b01
	} push_state_t;

endpackage

// file: verilog/flag_alu.sv
`timescale 1ns/1ps

module flag_alu
(
	// Operands
	input  wire logic [7:0]           a,
	input  wire logic [7:0]           b,
	input  wire logic                 cy_in,
	input  wire core_regs_pkg::alu_op_t op,
	// Results
	output logic      [7:0]           res_lo,
	output logic      [7:0]           res_hi,
	output logic                      cy,
	output logic                      ac,
	output logic                      ov
);

	logic [8:0]  sum;
	logic [4:0]  nib;
	logic [15:0] prod;
	logic        c;

	always_comb
	begin
		c      = (op == core_regs_pkg::OP_ADD) ? 1'b0 : cy_in;
		sum    = 9'h000;
		nib    = 5'h00;
		prod   = 16'h0000;
		res_lo = a;
		res_hi = 8'h00;
		cy     = 1'b0;
		ac     = 1'b0;
		ov     = 1'b0;
		case (op)
			core_regs_pkg::OP_ADD, core_regs_pkg::OP_ADD_WITH_CARRY:
			begin
				sum    = {1'b0, a} + {1'b0, b} + {8'h00, c};
				nib    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
				res_lo = sum[7:0];
				cy     = sum[8];
				ac     = nib[4];
				ov     = (a[7] == b[7]) && (sum[7] != a[7]);
			end
			core_regs_pkg::OP_SUBTRACT_WITH_BORROW:
			begin
				sum    = {1'b0, a} - {1'b0, b} - {8'h00, c};
				nib    = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
				res_lo = sum[7:0];
				cy     = sum[8];
				ac     = nib[4];
				ov     = (a[7] != b[7]) && (sum[7] != a[7]);
			end
			core_regs_pkg::OP_MUL:
			begin
				prod   = {8'h00, a} * {8'h00, b};
				res_lo = prod[7:0];
				res_hi = prod[15:8];
				ov     = |prod[15:8];
			end
			core_regs_pkg::OP_DIV:
			begin
				// Divide by zero leaves the operand untouched
				if (b == 8'h00)
				begin
					ov = 1'b1;
				end
				else
				begin
					res_lo = a / b;
					res_hi = a % b;
				end
			end
			default:
			begin
				res_lo = a;
			end
		endcase
	end

endmodule // flag_alu

// file: verification/regs_chk_asserts.sv
`timescale 1ns/1ps

// ====================================================
// Port checker for the status and pointer registers
module regs_chk
(
	// Clock and requests
	input wire logic			sys_clk,
	input wire logic			rst_b,
	input wire logic			clk_en,
	input wire logic			sfr_wr,
	input wire logic			sfr_bit_wr,
	input wire logic [7:0]		sfr_addr,
	input wire logic [7:0]		sfr_wdata,
	input wire logic			alu_go,
	input wire core_regs_pkg::alu_op_t	alu_op,
	input wire logic [7:0]		alu_operand_b,
	input wire logic			push_req,
	// Observed state
	input wire logic			push_busy,
	input wire logic			stack_wr_en,
	input wire logic [7:0]		stack_wr_addr,
	input wire logic [15:0]		sixteen_bit_pointer,
	input wire logic [7:0]		stack_top_index,
	input wire logic [7:0]		arith_main_operand,
	input wire logic [7:0]		flags_word,
	input wire logic [4:0]		bank_base_addr
);
	logic [8:0]	add_s;
	logic [4:0]	nib_s;
	logic		mul_ov;
	logic		wr_any;
	logic		quiet;
	logic		fw_wr;

	assign add_s = {1'b0, arith_main_operand} + {1'b0, alu_operand_b};
	assign nib_s = {1'b0, arith_main_operand[3:0]} + {1'b0, alu_operand_b[3:0]};
	assign mul_ov = (16'(arith_main_operand) * 16'(alu_operand_b)) > 16'h00ff;
	assign wr_any = sfr_wr | sfr_bit_wr;
	// Same-cycle register writes override results, so keep them out
	assign quiet = alu_go & clk_en & ~wr_any;
	assign fw_wr = wr_any & (sfr_addr == core_regs_pkg::FLAGS_WORD_OFS);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_push_taken;
		push_req && !push_busy && clk_en && !wr_any;
	endsequence
	sequence s_push_write;
		push_busy && stack_wr_en && stack_wr_addr == stack_top_index;
	endsequence

	a_reset_values: assert property (disable iff (1'b0)
		!rst_b |=> stack_top_index == 8'h07 && sixteen_bit_pointer == 16'h0000
		&& arith_main_operand == 8'h00 && flags_word == 8'h00)
		else $error("reset state wrong");
	a_pointer_high: assert property (
		sfr_wr && clk_en && sfr_addr == core_regs_pkg::POINTER_HIGH_BYTE_OFS
		|=> sixteen_bit_pointer ==
		{$past(sfr_wdata), $past(sixteen_bit_pointer[7:0])})
		else $error("pointer bytes wrong");
	a_push_order: assert property (
		s_push_taken |=> stack_top_index == $past(stack_top_index) + 8'h01
		##0 s_push_write ##1 !push_busy)
		else $error("push order wrong");
	a_bank_base: assert property (
		bank_base_addr == {flags_word[4:3], 3'b000})
		else $error("bank base wrong");
	a_parity_live: assert property (
		flags_word[0] == ^arith_main_operand)
		else $error("parity wrong");
	a_user_flags_hold: assert property (
		// Reset sampled on this edge may legally clear the user flags
		rst_b && !fw_wr |=> $stable(flags_word[5]) && $stable(flags_word[1]))
		else $error("user flag moved");
	a_status_write: assert property (
		sfr_wr && clk_en && !alu_go && sfr_addr == core_regs_pkg::FLAGS_WORD_OFS
		|=> flags_word[7:1] == $past(sfr_wdata[7:1]))
		else $error("status write wrong");
	a_add_carries: assert property (
		quiet && alu_op == core_regs_pkg::OP_ADD |=>
		flags_word[7] == $past(add_s[8]) && flags_word[6] == $past(nib_s[4]))
		else $error("add carries wrong");
	a_mul_overflow: assert property (
		quiet && alu_op == core_regs_pkg::OP_MUL |=>
		flags_word[2] == $past(mul_ov) && !flags_word[7])
		else $error("multiply overflow wrong");
endmodule // regs_chk

bind core_status_and_pointer_regs regs_chk regs_chk_i (.sys_clk, .rst_b,
	.clk_en, .sfr_wr, .sfr_bit_wr, .sfr_addr, .sfr_wdata, .alu_go, .alu_op,
	.alu_operand_b, .push_req, .push_busy, .stack_wr_en, .stack_wr_addr,
	.sixteen_bit_pointer, .stack_top_index, .arith_main_operand, .flags_word,
	.bank_base_addr);

// file: verification/test_core_status_and_pointer_regs.sv
`timescale 1ns/1ps

// ====================================================
// Bench for the status and pointer registers
module test_core_status_and_pointer_regs;
	localparam logic [7:0] FW = core_regs_pkg::FLAGS_WORD_OFS;
	typedef struct {
		core_regs_pkg::alu_op_t	op;
		logic [7:0]	a, b, res, hi;
		logic [2:0]	f;
	} row_t;
	// Flags column is carry, half carry, overflow; order matters for carry in
	row_t rows [9] = '{
		'{core_regs_pkg::OP_ADD, 8'h7f, 8'h01, 8'h80, 8'h00, 3'h3},
		'{core_regs_pkg::OP_ADD, 8'hff, 8'h01, 8'h00, 8'h00, 3'h6},
		'{core_regs_pkg::OP_ADD_WITH_CARRY, 8'h10, 8'h20, 8'h31, 8'h00, 3'h0},
		'{core_regs_pkg::OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h01, 8'hff, 8'h00, 3'h6},
		'{core_regs_pkg::OP_SUBTRACT_WITH_BORROW, 8'h80, 8'h00, 8'h7f, 8'h00, 3'h3},
		'{core_regs_pkg::OP_MUL, 8'h10, 8'h20, 8'h00, 8'h02, 3'h1},
		'{core_regs_pkg::OP_MUL, 8'h0f, 8'h11, 8'hff, 8'h00, 3'h0},
		'{core_regs_pkg::OP_DIV, 8'h64, 8'h07, 8'h0e, 8'h02, 3'h0},
		'{core_regs_pkg::OP_DIV, 8'h55, 8'h00, 8'h55, 8'h00, 3'h1}};
	logic sys_clk, rst_b, clk_en, sfr_wr, sfr_bit_wr, sfr_rd, sfr_rd_ack;
	logic alu_go, acc_load, push_req, pop_req, push_busy, stack_wr_en;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, alu_operand_b, alu_result_hi;
	logic [7:0] acc_load_data, push_data, stack_wr_addr, stack_wr_data;
	logic [7:0] stack_top_index, arith_main_operand, flags_word;
	logic [2:0] sfr_bit_sel;
	logic [15:0] sixteen_bit_pointer;
	logic [4:0] bank_base_addr;
	core_regs_pkg::alu_op_t alu_op;
	int n_mismatch = 0;
	int check_count = 0;

	core_status_and_pointer_regs core_status_and_pointer_regs_i (.sys_clk,
		.rst_b, .clk_en, .sfr_addr, .sfr_wr, .sfr_bit_wr, .sfr_bit_sel,
		.sfr_wdata, .sfr_rd, .sfr_rdata, .sfr_rd_ack, .alu_go, .alu_op,
		.alu_operand_b, .alu_result_hi, .acc_load, .acc_load_data, .push_req,
		.push_data, .pop_req, .push_busy, .stack_wr_en, .stack_wr_addr,
		.stack_wr_data, .sixteen_bit_pointer, .stack_top_index,
		.arith_main_operand, .flags_word, .bank_base_addr);

	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic chk(input string nm, input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict;
		if (n_mismatch == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Callers sit at a falling edge; drives land on the next rising edge
	task automatic wr(input logic [7:0] a, d, input logic bw, logic [2:0] bs);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= !bw;
		sfr_bit_wr <= bw;
		sfr_bit_sel <= bs;
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
		sfr_bit_wr <= 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, exp);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge sys_clk);
		sfr_rd <= 1'b0;
		@(negedge sys_clk);
		chk("ack", 16'(sfr_rd_ack), 16'h0001);
		chk("rdata", 16'(sfr_rdata), 16'(exp));
	endtask

	initial
	begin
		repeat (5000) @(posedge sys_clk);
		n_mismatch++;
		print_verdict();
	end

	initial
	begin
		{rst_b, sfr_wr, sfr_bit_wr, sfr_rd, alu_go, acc_load} = '0;
		{push_req, pop_req, sfr_bit_sel, sfr_addr, sfr_wdata} = '0;
		{alu_operand_b, acc_load_data, push_data} = '0;
		alu_op = core_regs_pkg::OP_ADD;
		clk_en = 1'b1;
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(negedge sys_clk);
		chk("index", 16'(stack_top_index), 16'h0007);
		wr(FW, 8'h22, 1'b0, 3'h0);
		foreach (rows[i])
		begin
			@(posedge sys_clk);
			acc_load <= 1'b1;
			acc_load_data <= rows[i].a;
			@(posedge sys_clk);
			acc_load <= 1'b0;
			alu_go <= 1'b1;
			alu_op <= rows[i].op;
			alu_operand_b <= rows[i].b;
			@(posedge sys_clk);
			alu_go <= 1'b0;
			@(negedge sys_clk);
			chk("result", {alu_result_hi, arith_main_operand},
				{rows[i].hi, rows[i].res});
			chk("flags", 16'(flags_word), 16'({rows[i].f[2:1], 3'b100,
				rows[i].f[0], 1'b1, ^rows[i].res}));
		end
		wr(core_regs_pkg::POINTER_HIGH_BYTE_OFS, 8'h12, 1'b0, 3'h0);
		wr(core_regs_pkg::POINTER_LOW_BYTE_OFS, 8'h34, 1'b0, 3'h0);
		chk("pointer", sixteen_bit_pointer, 16'h1234);
		rd(core_regs_pkg::POINTER_HIGH_BYTE_OFS, 8'h12);
		wr(8'h84, 8'h5a, 1'b0, 3'h0);
		rd(8'h84, core_regs_pkg::UNMAPPED_READ_VAL);
		chk("pointer", sixteen_bit_pointer, 16'h1234);
		for (int k = 0; k < 4; k++)
		begin
			wr(FW, 8'(k << 3), 1'b0, 3'h0);
			chk("bank", 16'(bank_base_addr), 16'(k * 8));
		end
		// Accumulator holds 0x55 here, so parity reads zero
		wr(FW, 8'hff, 1'b0, 3'h0);
		chk("flags", 16'(flags_word), 16'h00fe);
		wr(FW, 8'h01, 1'b1, 3'h0);
		chk("flags", 16'(flags_word), 16'h00fe);
		wr(FW, 8'h00, 1'b1, 3'h5);
		chk("flags", 16'(flags_word), 16'h00de);
		rd(FW, 8'hde);
		wr(core_regs_pkg::ARITH_MAIN_OPERAND_OFS, 8'h07, 1'b0, 3'h0);
		chk("parity", 16'(flags_word), 16'h00df);
		@(posedge sys_clk);
		push_req <= 1'b1;
		push_data <= 8'haa;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk("index", 16'(stack_top_index), 16'h0008);
		chk("wr_en", 16'(stack_wr_en), 16'h0001);
		chk("stack_wr", {stack_wr_addr, stack_wr_data}, 16'h08aa);
		@(posedge sys_clk);
		push_req <= 1'b0;
		@(negedge sys_clk);
		chk("refused", 16'(stack_top_index), 16'h0008);
		// A low enable must freeze the index even with a pop pending
		@(posedge sys_clk);
		pop_req <= 1'b1;
		clk_en <= 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk("frozen", 16'(stack_top_index), 16'h0008);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		@(posedge sys_clk);
		pop_req <= 1'b0;
		@(negedge sys_clk);
		chk("pop", 16'(stack_top_index), 16'h0007);
		rd(core_regs_pkg::STACK_TOP_INDEX_OFS, 8'h07);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		@(posedge sys_clk);
		rst_b <= 1'b1;
		@(negedge sys_clk);
		chk("reset", {stack_top_index, flags_word}, 16'h0700);
		chk("reset", {arith_main_operand, sixteen_bit_pointer[15:8]},
			16'h0000);
		chk("reset", sixteen_bit_pointer, 16'h0000);
		chk("reset", {sfr_rdata, 7'h00, sfr_rd_ack}, 16'h0000);
		// Let the checker see the edges after the second release
		repeat (2) @(posedge sys_clk);
		print_verdict();
	end
endmodule // test_core_status_and_pointer_regs
